// file: rtl/adc_sel_pkg.sv
// package of constants, types and carriers for the dual converter channel select block
package adc_sel_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_COMPARATOR_CS = 8'h30;
  localparam logic [7:0] ADDR_RESULT_LOW    = 8'h78;
  localparam logic [7:0] ADDR_RESULT_HIGH   = 8'h79;
  localparam logic [7:0] ADDR_CONTROL_A     = 8'h7A;
  localparam logic [7:0] ADDR_CONTROL_B     = 8'h7B;
  localparam logic [7:0] ADDR_CHANNEL_SEL   = 8'h7C;
  localparam logic [7:0] ADDR_DIGITAL_DIS   = 8'h7F;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // control register a fields
  localparam int CTRL_BIT_ENABLE = 7;
  localparam int CTRL_BIT_START  = 6;
  localparam int CTRL_BIT_DONE   = 4;

  // control register b fields
  localparam int              CSRB_BIT_CMP_MUX_EN = 6;
  localparam int              CSRB_BIT_MODULE_SEL = 5;
  localparam logic [7:0]      CSRB_WRITE_MASK     = 8'h67;
  localparam logic [2:0]      TRIG_COMPARATOR     = 3'h1;

  // channel select fields
  localparam int              MUX_CODE_W   = 4;
  localparam int              CHAN_INDEX_W = 3;
  localparam logic [3:0]      CODE_TEMP    = 4'h8;
  localparam logic [3:0]      CODE_BANDGAP = 4'hE;
  localparam logic [3:0]      CODE_GROUND  = 4'hF;
  localparam logic [3:0]      INPUT_BASE   = 4'h1;

  // result scaling
  localparam int              RESULT_W       = 10;
  localparam int              RESULT_HIGH_W  = RESULT_W - 8;
  localparam int              BANDGAP_MV     = 1100;
  localparam int              REF_MV         = 3300;
  localparam int              FULL_SCALE     = 1023;
  localparam logic [9:0]      BANDGAP_RESULT = 10'(BANDGAP_MV * FULL_SCALE / REF_MV);
  localparam logic [9:0]      ZERO_RESULT    = 10'h000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT,
    ST_SUBST
  } conv_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic       start;
    logic       module_sel;
    logic [3:0] input_num;
  } conv_req_s;

  typedef struct packed {
    logic       done;
    logic [9:0] data;
  } conv_rsp_s;

  typedef struct packed {
    conv_state_e state;
    logic        enable;
    logic        done;
    logic [7:0]  control_b;
    logic [7:0]  channel_sel;
    logic [9:0]  result;
    logic        module_sel;
    logic [3:0]  input_num;
    logic [9:0]  subst_value;
    logic [7:0]  rdata;
  } state_s;

endpackage

// file: rtl/result_compute.sv
// channel code decode: real input routing or substituted result
`timescale 1ns/1ps
module result_compute (
  // selection
  input  wire logic [3:0] mux_code,
  input  wire logic       module_sel,
  // decision
  output logic            substitute,
  output logic [9:0]      subst_value,
  output logic            conv_module,
  output logic [3:0]      conv_input
);

  always_comb begin
    substitute  = 1'b0;
    subst_value = adc_sel_pkg::ZERO_RESULT;
    conv_module = module_sel;
    // input n of a module is reached by field value n-1
    conv_input  = 4'({1'b0, mux_code[adc_sel_pkg::CHAN_INDEX_W-1:0]}) + adc_sel_pkg::INPUT_BASE;
    if (mux_code[adc_sel_pkg::MUX_CODE_W-1]) begin
      // every code with the top bit set is answered without touching a converter
      substitute = 1'b1;
      case (mux_code)
        adc_sel_pkg::CODE_BANDGAP: subst_value = adc_sel_pkg::BANDGAP_RESULT;
        adc_sel_pkg::CODE_GROUND:  subst_value = adc_sel_pkg::ZERO_RESULT;
        adc_sel_pkg::CODE_TEMP:    subst_value = adc_sel_pkg::ZERO_RESULT;
        default:                   subst_value = adc_sel_pkg::ZERO_RESULT;
      endcase
    end
  end

endmodule

// file: rtl/dual_adc_channel_select.sv
// dual converter channel selection, result substitution and register file
`timescale 1ns/1ps
module dual_adc_channel_select (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // register port
  input  wire adc_sel_pkg::reg_req_s reg_req,
  output logic [7:0]                 reg_rdata,
  // converter side
  output adc_sel_pkg::conv_req_s     conv_req,
  input  wire adc_sel_pkg::conv_rsp_s conv_rsp,
  // status
  output logic                       busy
);

  adc_sel_pkg::state_s st;
  adc_sel_pkg::state_s next_st;

  logic       substitute;
  logic [9:0] subst_value;
  logic       route_module;
  logic [3:0] route_input;

  result_compute u_result_compute (
    .mux_code    (st.channel_sel[adc_sel_pkg::MUX_CODE_W-1:0]),
    .module_sel  (st.control_b[adc_sel_pkg::CSRB_BIT_MODULE_SEL]),
    .substitute  (substitute),
    .subst_value (subst_value),
    .conv_module (route_module),
    .conv_input  (route_input)
  );

  function automatic logic hit(input adc_sel_pkg::reg_req_s req, input logic [7:0] addr);
    hit = req.addr == addr;
  endfunction

  logic write_a;
  logic start_req;
  logic finish;
  logic clear_done;

  always_comb begin
    write_a    = reg_req.wr && hit(reg_req, adc_sel_pkg::ADDR_CONTROL_A);
    start_req  = write_a && reg_req.wdata[adc_sel_pkg::CTRL_BIT_START];
    clear_done = write_a && reg_req.wdata[adc_sel_pkg::CTRL_BIT_DONE];
    finish     = 1'b0;
    next_st    = st;

    // register writes
    if (write_a) begin
      next_st.enable = reg_req.wdata[adc_sel_pkg::CTRL_BIT_ENABLE];
    end
    if (reg_req.wr && hit(reg_req, adc_sel_pkg::ADDR_CONTROL_B)) begin
      // comparator enable and trigger code are only stored; nothing here acts on them
      next_st.control_b = reg_req.wdata & adc_sel_pkg::CSRB_WRITE_MASK;
    end
    if (reg_req.wr && hit(reg_req, adc_sel_pkg::ADDR_CHANNEL_SEL)) begin
      next_st.channel_sel = reg_req.wdata;
    end
    // writes to the comparator and input-disable addresses fall through unstored

    // conversion sequence
    case (st.state)
      adc_sel_pkg::ST_IDLE: begin
        if (start_req && next_st.enable) begin
          next_st.module_sel  = route_module;
          next_st.input_num   = route_input;
          next_st.subst_value = subst_value;
          // a channel write in the same cycle lands after this decode
          if (substitute) begin
            next_st.state = adc_sel_pkg::ST_SUBST;
          end else begin
            next_st.state = adc_sel_pkg::ST_ISSUE;
          end
        end
      end
      adc_sel_pkg::ST_ISSUE: begin
        next_st.state = adc_sel_pkg::ST_WAIT;
      end
      adc_sel_pkg::ST_WAIT: begin
        if (conv_rsp.done) begin
          next_st.result = conv_rsp.data;
          finish         = 1'b1;
          next_st.state  = adc_sel_pkg::ST_IDLE;
        end
      end
      adc_sel_pkg::ST_SUBST: begin
        // same finishing path as a real conversion
        next_st.result = st.subst_value;
        finish         = 1'b1;
        next_st.state  = adc_sel_pkg::ST_IDLE;
      end
      default: begin
        next_st.state = adc_sel_pkg::ST_IDLE;
      end
    endcase

    // dropping enable abandons a conversion in flight
    if (!next_st.enable && st.state != adc_sel_pkg::ST_IDLE) begin
      next_st.state = adc_sel_pkg::ST_IDLE;
      finish        = 1'b0;
    end

    // completion flag: a finish in the clearing cycle wins
    if (finish) begin
      next_st.done = 1'b1;
    end else if (clear_done) begin
      next_st.done = 1'b0;
    end

    // read data, one cycle after the strobe, zero elsewhere
    next_st.rdata = adc_sel_pkg::RESET_BYTE;
    if (reg_req.rd) begin
      case (reg_req.addr)
        adc_sel_pkg::ADDR_RESULT_LOW:    next_st.rdata = st.result[7:0];
        adc_sel_pkg::ADDR_RESULT_HIGH:   next_st.rdata = {6'h00, st.result[adc_sel_pkg::RESULT_W-1:8]};
        adc_sel_pkg::ADDR_CONTROL_A: begin
          next_st.rdata                              = adc_sel_pkg::RESET_BYTE;
          next_st.rdata[adc_sel_pkg::CTRL_BIT_ENABLE] = st.enable;
          next_st.rdata[adc_sel_pkg::CTRL_BIT_START]  = st.state != adc_sel_pkg::ST_IDLE;
          next_st.rdata[adc_sel_pkg::CTRL_BIT_DONE]   = st.done;
        end
        adc_sel_pkg::ADDR_CONTROL_B:     next_st.rdata = st.control_b;
        adc_sel_pkg::ADDR_CHANNEL_SEL:   next_st.rdata = st.channel_sel;
        adc_sel_pkg::ADDR_COMPARATOR_CS: next_st.rdata = adc_sel_pkg::RESET_BYTE;
        adc_sel_pkg::ADDR_DIGITAL_DIS:   next_st.rdata = adc_sel_pkg::RESET_BYTE;
        default:                         next_st.rdata = adc_sel_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st.state       <= adc_sel_pkg::ST_IDLE;
      st.enable      <= 1'b0;
      st.done        <= 1'b0;
      st.control_b   <= adc_sel_pkg::RESET_BYTE;
      st.channel_sel <= adc_sel_pkg::RESET_BYTE;
      st.result      <= adc_sel_pkg::ZERO_RESULT;
      st.module_sel  <= 1'b0;
      st.input_num   <= adc_sel_pkg::INPUT_BASE;
      st.subst_value <= adc_sel_pkg::ZERO_RESULT;
      st.rdata       <= adc_sel_pkg::RESET_BYTE;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    reg_rdata            = st.rdata;
    conv_req.start       = st.state == adc_sel_pkg::ST_ISSUE;
    conv_req.module_sel  = st.module_sel;
    conv_req.input_num   = st.input_num;
    busy                 = st.state != adc_sel_pkg::ST_IDLE;
  end

endmodule

// file: tb/adc_sel_checker.sv
// assertion checker for the dual converter channel select block
`timescale 1ns/1ps
module adc_sel_checker (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   resetn,
  // watched ports
  input wire adc_sel_pkg::reg_req_s  reg_req,
  input wire logic [7:0]             reg_rdata,
  input wire adc_sel_pkg::conv_req_s conv_req,
  input wire adc_sel_pkg::conv_rsp_s conv_rsp,
  input wire logic                   busy
);
  logic [3:0] chan;
  logic       modb;
  logic       take;
  assign take = reg_req.wr && reg_req.addr == 8'h7A && reg_req.wdata[7:6] == 2'b11 && !busy;
  // shadow of the selection as software last wrote it
  always_ff @(posedge clock) begin
    if (!resetn) begin
      chan <= 4'h0;
      modb <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == 8'h7C) begin
      chan <= reg_req.wdata[3:0];
    end else if (reg_req.wr && reg_req.addr == 8'h7B) begin
      modb <= reg_req.wdata[5];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence subst_s;
    busy && !conv_req.start ##1 !busy;
  endsequence
  a_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_rd_unimpl: assert property (reg_req.rd && (reg_req.addr == 8'h30 || reg_req.addr == 8'h7F) |=> !reg_rdata)
    else $error("unimplemented register reads nonzero");
  a_start_pulse: assert property (conv_req.start |=> !conv_req.start)
    else $error("start longer than one cycle");
  a_start_busy: assert property (conv_req.start |-> busy)
    else $error("start without busy");
  a_take_route: assert property (take && !chan[3] |=> conv_req.start && conv_req.module_sel == modb
    && conv_req.input_num == {1'b0, chan[2:0]} + 4'h1) else $error("wrong converter input");
  a_subst_fast: assert property (take && chan[3] |=> subst_s)
    else $error("substituted code did not finish in two cycles");
  a_done_ends: assert property (busy && !conv_req.start && conv_rsp.done |=> !busy)
    else $error("busy after converter answer");
  a_sel_held: assert property (busy |=> $stable(conv_req.module_sel) && $stable(conv_req.input_num))
    else $error("selection moved during conversion");
endmodule
bind dual_adc_channel_select adc_sel_checker chk_i (.clock(clock), .resetn(resetn), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .conv_req(conv_req), .conv_rsp(conv_rsp), .busy(busy));

// file: tb/conv_model.sv
// behavioural model of the two eight-input converters
`timescale 1ns/1ps
module conv_model (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   resetn,
  // request and answer delay
  input  wire adc_sel_pkg::conv_req_s conv_req,
  input  wire logic [7:0]             slow,
  // answer
  output adc_sel_pkg::conv_rsp_s      conv_rsp
);
  logic       run;
  logic [7:0] cnt;
  logic [4:0] tag;
  initial conv_rsp = '0;
  always @(posedge clock) begin
    conv_rsp.done <= 1'b0;
    // data toggles between answers so a late sample cannot pass
    conv_rsp.data <= ~conv_rsp.data;
    if (!resetn) begin
      run <= 1'b0;
    end else if (conv_req.start) begin
      run <= 1'b1;
      cnt <= slow;
      tag <= {conv_req.module_sel, conv_req.input_num};
    end else if (run && cnt == 8'h00) begin
      run <= 1'b0;
      conv_rsp <= '{done: 1'b1, data: {tag, 5'h15}};
    end else if (run) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule

// file: tb/tb.sv
// self-checking bench for the dual converter channel select block
`timescale 1ns/1ps
module tb;
  logic                   clock;
  logic                   resetn;
  adc_sel_pkg::reg_req_s  req;
  logic [7:0]             rdata;
  adc_sel_pkg::conv_req_s creq;
  adc_sel_pkg::conv_rsp_s crsp;
  logic                   busy;
  logic [7:0]             slow;
  logic [7:0]             v;
  logic [7:0]             lo;
  int                     n_errors;
  int                     check_count;
  int                     cycles;
  // control b, channel select, expected result
  logic [25:0] rows [6] = '{{8'h00, 8'h00, 10'h035}, {8'h20, 8'h07, 10'h315}, {8'h61, 8'h03, 10'h295},
                            {8'h41, 8'h08, 10'h000}, {8'h00, 8'h0E, 10'h155}, {8'h20, 8'h0F, 10'h000}};
  logic [7:0]  addrs [7] = '{8'h30, 8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7F};
  dual_adc_channel_select dut (.clock(clock), .resetn(resetn), .reg_req(req), .reg_rdata(rdata),
    .conv_req(creq), .conv_rsp(crsp), .busy(busy));
  conv_model far (.clock(clock), .resetn(resetn), .conv_req(creq), .slow(slow), .conv_rsp(crsp));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic run(input logic [7:0] cb, input logic [7:0] ch, input logic [9:0] exp);
    wr(8'h7B, cb);
    wr(8'h7C, ch);
    wr(8'h7A, 8'hC0);
    // bounded wait for completion
    for (int k = 0; k < 300 && !(busy === 1'b0 && k > 0); k++) begin
      @(posedge clock);
      #1;
    end
    rd(8'h78, lo);
    rd(8'h79, v);
    chk({v[1:0], lo}, exp);
    rd(8'h7A, v);
    chk({2'b00, v}, 10'h090);
    wr(8'h7A, 8'h90);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    req = '0;
    slow = 8'h00;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    foreach (addrs[i]) begin
      rd(addrs[i], v);
      chk({2'b00, v}, 10'h000);
    end
    wr(8'h30, 8'hFF);
    wr(8'h7F, 8'hFF);
    wr(8'h7B, 8'hFF);
    rd(8'h30, v);
    chk({2'b00, v}, 10'h000);
    rd(8'h7F, v);
    chk({2'b00, v}, 10'h000);
    rd(8'h7B, v);
    chk({2'b00, v}, 10'h067);
    foreach (rows[i]) begin
      slow <= 8'(i * 5);
      run(rows[i][25:18], rows[i][17:10], rows[i][9:0]);
    end
    slow <= 8'h28;
    wr(8'h7C, 8'h02);
    run(8'h00, 8'h02, 10'h075);
    // a second start and a new channel while busy must not disturb the running conversion
    wr(8'h7B, 8'h20);
    wr(8'h7C, 8'h05);
    wr(8'h7A, 8'hC0);
    wr(8'h7C, 8'h0F);
    wr(8'h7B, 8'h00);
    wr(8'h7A, 8'hC0);
    repeat (60) @(posedge clock);
    rd(8'h78, lo);
    rd(8'h79, v);
    chk({v[1:0], lo}, 10'h2D5);
    rd(8'h7C, v);
    chk({2'b00, v}, 10'h00F);
    // dropping enable mid conversion abandons it: no done, result kept
    wr(8'h7A, 8'h90);
    wr(8'h7C, 8'h01);
    wr(8'h7A, 8'hC0);
    wr(8'h7A, 8'h00);
    repeat (50) @(posedge clock);
    rd(8'h7A, v);
    chk({2'b00, v}, 10'h000);
    rd(8'h78, v);
    chk({2'b00, v}, 10'h0D5);
    tally_and_finish();
  end
endmodule
